// ==== src/startup_status_registers.sv ====
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// - Temperature code read-only in bits 14:0
// - Reset-done set on sequence done or lock
// - Load-complete set when startup loading ends
// - EEPROM-valid set on good EEPROM user load
// - OTP-valid set on good OTP user load
// - OTP checksum error flag on CRC mismatch
// - Loaded config field: 0 common, 1-4 user
// - Interrupt module at 0x40: enable 0x0, status 0x8
// - Enabled status bits drive the interrupt output
module startup_status_registers #(
  parameter int INT_W = startup_status_pkg::INT_W
) (
  // Clock and reset
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_i,
  // Wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  // Startup sequencer, loader and sensor
  input  wire startup_status_pkg::boot_in_t  boot_i,
  input  wire startup_status_pkg::temp_in_t  temp_i,
  input  wire logic [INT_W-1:0]              ext_evt_i,
  // Interrupt
  output logic                               irq_o
);

  logic [31:0]                     dat_r;
  logic                            ack_r;
  logic [14:0]                     temp_r;
  logic                            rst_done_r;
  logic                            ready_r;
  logic                            ee_valid_r;
  logic                            otp_valid_r;
  logic                            crc_r;
  logic [2:0]                      cfg_r;
  startup_status_pkg::load_phase_t phase_r;
  logic                            rst_done_d_r;
  logic                            ready_d_r;
  logic [INT_W-1:0]                evt;
  logic [INT_W-1:0]                int_en;
  logic [INT_W-1:0]                int_sts;
  logic                            irq;
  logic                            req;
  logic                            wr_fire;
  logic                            int_hit;
  logic [7:0]                      int_ofs;
  logic [31:0]                     rd_nxt;
  logic                            user_id;
  logic                            good_load;
  logic                            cfg_take;

  assign req     = wb_cyc_i && wb_stb_i;
  // Write lands at the edge where the master sees ack
  assign wr_fire = req && wb_we_i && ack_r;
  assign int_ofs = wb_adr_i - startup_status_pkg::INT_BASE;
  assign int_hit = wb_adr_i[7:4] == startup_status_pkg::INT_BASE[7:4];

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= req && !ack_r;
  end

  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (int_hit)
    begin
      case (int_ofs[3:2])
        2'h0: rd_nxt = int_en[31:0];
        2'h1: rd_nxt = int_en[63:32];
        2'h2: rd_nxt = int_sts[31:0];
        2'h3: rd_nxt = int_sts[63:32];
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
    else if (wb_adr_i[7:2] == startup_status_pkg::TEMP_OFS[7:2])
      rd_nxt[14:0] = temp_r;
    else if (wb_adr_i[7:2] == startup_status_pkg::STARTUP_OFS[7:2])
    begin
      rd_nxt[startup_status_pkg::RST_DONE_BIT]  = rst_done_r;
      rd_nxt[startup_status_pkg::READY_BIT]     = ready_r;
      rd_nxt[startup_status_pkg::EE_VALID_BIT]  = ee_valid_r;
      rd_nxt[startup_status_pkg::OTP_VALID_BIT] = otp_valid_r;
      rd_nxt[startup_status_pkg::CRC_ERR_BIT]   = crc_r;
      rd_nxt[2:0]                               = cfg_r;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      dat_r <= 32'h0000_0000;
    else if (req && !ack_r)
      dat_r <= rd_nxt;
  end

  // Sensor code taken on each valid sample; bus writes never reach it
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      temp_r <= startup_status_pkg::TEMP_RST;
    else if (temp_i.valid)
      temp_r <= temp_i.code;
  end

  // Sticky startup flags; a new event beats restart
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rst_done_r <= 1'b0;
    else if (boot_i.seq_done || boot_i.dpll_lock)
      rst_done_r <= 1'b1;
    else if (boot_i.restart)
      rst_done_r <= 1'b0;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ready_r <= 1'b0;
    else if (boot_i.load_done)
      ready_r <= 1'b1;
    else if (boot_i.restart)
      ready_r <= 1'b0;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      crc_r <= 1'b0;
    else if (boot_i.crc_err)
      crc_r <= 1'b1;
    else if (boot_i.restart)
      crc_r <= 1'b0;
  end

  assign user_id   = boot_i.cfg_id != startup_status_pkg::CFG_COMMON &&
                     boot_i.cfg_id <= startup_status_pkg::CFG_USER_LAST;
  assign good_load = boot_i.cfg_strobe && boot_i.cfg_ok;
  // User loads before the common one are not recorded
  assign cfg_take  = good_load && user_id &&
                     phase_r != startup_status_pkg::PH_WAIT_COMMON;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      phase_r <= startup_status_pkg::PH_WAIT_COMMON;
    else if (boot_i.restart)
      phase_r <= startup_status_pkg::PH_WAIT_COMMON;
    else
    begin
      case (phase_r)
        startup_status_pkg::PH_WAIT_COMMON:
          if (good_load &&
              boot_i.cfg_id == startup_status_pkg::CFG_COMMON)
            phase_r <= startup_status_pkg::PH_USER;
        startup_status_pkg::PH_USER:
          if (boot_i.load_done)
            phase_r <= startup_status_pkg::PH_READY;
        startup_status_pkg::PH_READY:
          phase_r <= startup_status_pkg::PH_READY;
        default:
          phase_r <= startup_status_pkg::PH_WAIT_COMMON;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cfg_r <= startup_status_pkg::CFG_RST;
    else if (boot_i.restart)
      cfg_r <= startup_status_pkg::CFG_RST;
    else if (good_load &&
             boot_i.cfg_id == startup_status_pkg::CFG_COMMON)
      cfg_r <= startup_status_pkg::CFG_COMMON;
    else if (cfg_take)
      cfg_r <= boot_i.cfg_id;
  end

  // Source flags follow the latest recorded user load
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ee_valid_r  <= 1'b0;
      otp_valid_r <= 1'b0;
    end
    else if (boot_i.restart)
    begin
      ee_valid_r  <= 1'b0;
      otp_valid_r <= 1'b0;
    end
    else if (cfg_take)
    begin
      ee_valid_r  <= boot_i.from_eeprom;
      otp_valid_r <= !boot_i.from_eeprom;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rst_done_d_r <= 1'b0;
      ready_d_r    <= 1'b0;
    end
    else
    begin
      rst_done_d_r <= rst_done_r;
      ready_d_r    <= ready_r;
    end
  end

  always_comb
  begin
    evt = ext_evt_i;
    evt[startup_status_pkg::EVT_RST_DONE] = rst_done_r && !rst_done_d_r;
    evt[startup_status_pkg::EVT_READY]    = ready_r && !ready_d_r;
    evt[startup_status_pkg::EVT_CRC_ERR]  = boot_i.crc_err;
  end

  irq_regs #(
    .W (INT_W)
  ) u_irq (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .wr_i       (wr_fire && int_hit),
    .word_i     (int_ofs[3:2]),
    .wdat_i     (wb_dat_i),
    .sel_i      (wb_sel_i),
    .evt_i      (evt),
    .en_o       (int_en),
    .sts_o      (int_sts),
    .irq_o      (irq)
  );

  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;
  assign irq_o    = irq;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  ack_one_cycle_a: assert property (
    req && !ack_r |=> ack_r ##1 !ack_r)
    else $error("ack not a single cycle pulse");

  temp_read_a: assert property (
    req && !ack_r && !wb_we_i && wb_adr_i == 8'h00
    |=> wb_dat_o == {17'h00000, $past(temp_r)})
    else $error("temperature read mismatch");

  rst_done_set_a: assert property (
    boot_i.seq_done || boot_i.dpll_lock |=> rst_done_r)
    else $error("reset done not set");

  ready_set_a: assert property (
    boot_i.load_done |=> ready_r)
    else $error("load complete not set");

  crc_hold_a: assert property (
    crc_r && !boot_i.restart |=> crc_r)
    else $error("crc flag lost without restart");

  source_excl_a: assert property (
    !(ee_valid_r && otp_valid_r))
    else $error("both load sources flagged");

  otp_valid_a: assert property (
    cfg_take && !boot_i.from_eeprom && !boot_i.restart
    |=> otp_valid_r && cfg_r == $past(boot_i.cfg_id))
    else $error("otp user load not recorded");

  cfg_range_a: assert property (
    cfg_r <= startup_status_pkg::CFG_USER_LAST)
    else $error("config field out of range");

  common_first_a: assert property (
    phase_r == startup_status_pkg::PH_WAIT_COMMON
    |-> cfg_r == startup_status_pkg::CFG_COMMON)
    else $error("user config before common");

  irq_mask_a: assert property (
    (int_sts & int_en) != 64'h0 |=> irq_o)
    else $error("unmasked status without interrupt");

  // Loader traffic in the same cycle may move the field legally
  status_ro_a: assert property (
    wr_fire && wb_adr_i == 8'h04 && !boot_i.restart &&
    !boot_i.cfg_strobe |=> $stable(cfg_r))
    else $error("write changed startup status");

  ee_valid_a: assert property (
    cfg_take && boot_i.from_eeprom && !boot_i.restart
    |=> ee_valid_r && !otp_valid_r && cfg_r == $past(boot_i.cfg_id))
    else $error("eeprom user load not recorded");

  user_early_a: assert property (
    good_load && user_id && !boot_i.restart &&
    phase_r == startup_status_pkg::PH_WAIT_COMMON
    |=> $stable(cfg_r) && $stable(ee_valid_r) && $stable(otp_valid_r))
    else $error("user config taken before common");

  restart_clear_a: assert property (
    boot_i.restart && !boot_i.seq_done && !boot_i.dpll_lock &&
    !boot_i.load_done && !boot_i.crc_err
    |=> !rst_done_r && !ready_r && !crc_r && !ee_valid_r &&
        !otp_valid_r && cfg_r == startup_status_pkg::CFG_RST)
    else $error("restart left startup flags set");

  temp_hold_a: assert property (
    !temp_i.valid |=> $stable(temp_r))
    else $error("sensor code moved without a sample");

  cfg_common_a: assert property (
    good_load && boot_i.cfg_id == startup_status_pkg::CFG_COMMON &&
    !boot_i.restart |=> cfg_r == startup_status_pkg::CFG_COMMON)
    else $error("common load not reported");

  reserved_zero_a: assert property (
    req && !ack_r && !wb_we_i &&
    wb_adr_i[7:2] == startup_status_pkg::STARTUP_OFS[7:2]
    |=> wb_dat_o[31:8] == 24'h00_0000)
    else $error("reserved status bits not zero");

  irq_quiet_a: assert property (
    (int_sts & int_en) == '0 |=> !irq_o)
    else $error("masked status raised the interrupt");

  crc_event_a: assert property (
    boot_i.crc_err |=> int_sts[startup_status_pkg::EVT_CRC_ERR])
    else $error("crc error not latched as event");

  ready_seen_c: cover property (
    boot_i.load_done ##1 ready_r);
  irq_seen_c: cover property (
    !irq_o ##1 irq_o);
  crc_seen_c: cover property (
    boot_i.crc_err ##1 crc_r);
  user_load_c: cover property (
    cfg_take ##1 (ee_valid_r || otp_valid_r));

endmodule : startup_status_registers

// ==== shared/startup_status_pkg.sv ====
package startup_status_pkg;

  // Byte addresses on the register bus; interrupt offsets relative to INT_BASE
  localparam logic [7:0] TEMP_OFS    = 8'h00;
  localparam logic [7:0] STARTUP_OFS = 8'h04;
  localparam logic [7:0] INT_BASE    = 8'h40;
  localparam logic [7:0] INT_EN_OFS  = 8'h00;
  localparam logic [7:0] INT_STS_OFS = 8'h08;

  // Field positions
  localparam int TEMP_W        = 15;
  localparam int RST_DONE_BIT  = 7;
  localparam int READY_BIT     = 6;
  localparam int EE_VALID_BIT  = 5;
  localparam int OTP_VALID_BIT = 4;
  localparam int CRC_ERR_BIT   = 3;
  localparam int CFG_LSB       = 0;
  localparam int CFG_W         = 3;

  // Configuration codes
  localparam logic [2:0] CFG_COMMON    = 3'h0;
  localparam logic [2:0] CFG_USER_LAST = 3'h4;

  // Reset values
  localparam logic [14:0] TEMP_RST = 15'h0000;
  localparam logic [2:0]  CFG_RST  = 3'h0;

  // Interrupt width and internal event positions
  localparam int INT_W         = 64;
  localparam int EVT_RST_DONE  = 0;
  localparam int EVT_READY     = 1;
  localparam int EVT_CRC_ERR   = 2;
  localparam int EVT_INTERNAL  = 3;

  typedef struct packed {
    logic       restart;
    logic       seq_done;
    logic       dpll_lock;
    logic       load_done;
    logic       cfg_strobe;
    logic [2:0] cfg_id;
    logic       cfg_ok;
    logic       from_eeprom;
    logic       crc_err;
  } boot_in_t;

  typedef struct packed {
    logic        valid;
    logic [14:0] code;
  } temp_in_t;

  typedef enum logic [1:0] {
    PH_WAIT_COMMON,
    PH_USER,
    PH_READY
  } load_phase_t;

endpackage : startup_status_pkg

// ==== src/irq_regs.sv ====
`timescale 1ns/100ps
module irq_regs #(
  parameter int W = 64
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  // Word access, already qualified
  input  wire logic         wr_i,
  input  wire logic [1:0]   word_i,
  input  wire logic [31:0]  wdat_i,
  input  wire logic [3:0]   sel_i,
  // Events and state
  input  wire logic [W-1:0] evt_i,
  output logic      [W-1:0] en_o,
  output logic      [W-1:0] sts_o,
  output logic              irq_o
);

  logic [W-1:0] en_r;
  logic [W-1:0] sts_r;
  logic         irq_r;

  genvar b;
  generate
    for (b = 0; b < W; b++)
    begin : g_bit
      logic lane;
      assign lane = sel_i[(b % 32) / 8] && (word_i[0] == (b >= 32));
      always_ff @(posedge core_clk_i or posedge rst_i)
      begin
        if (rst_i)
          en_r[b] <= 1'b0;
        else if (wr_i && lane && !word_i[1])
          en_r[b] <= wdat_i[b % 32];
      end
      // Set wins over a write-one clear
      always_ff @(posedge core_clk_i or posedge rst_i)
      begin
        if (rst_i)
          sts_r[b] <= 1'b0;
        else if (evt_i[b])
          sts_r[b] <= 1'b1;
        else if (wr_i && lane && word_i[1] && wdat_i[b % 32])
          sts_r[b] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_r <= 1'b0;
    else
      irq_r <= |(sts_r & en_r);
  end

  assign en_o  = en_r;
  assign sts_o = sts_r;
  assign irq_o = irq_r;

endmodule : irq_regs

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
module testbench;

  typedef struct packed {
    logic [2:0]  id;
    logic        ee;
    logic        lock;
    logic [31:0] exp;
  } row_t;

  logic                         core_clk_i;
  logic                         rst_i;
  logic                         wb_cyc_i;
  logic                         wb_stb_i;
  logic                         wb_we_i;
  logic [7:0]                   wb_adr_i;
  logic [3:0]                   wb_sel_i;
  logic [31:0]                  wb_dat_i;
  logic [31:0]                  wb_dat_o;
  logic                         wb_ack_o;
  startup_status_pkg::boot_in_t boot_i;
  startup_status_pkg::temp_in_t temp_i;
  logic [63:0]                  ext_evt_i;
  logic                         irq_o;
  int                           num_errors = 0;
  int                           checks_done = 0;
  int                           cycles = 0;
  logic [31:0]                  rd;
  row_t                         rows [4];

  startup_status_registers #(
    .INT_W(64)
  ) startup_status_registers_i (
    .core_clk_i(core_clk_i),
    .rst_i     (rst_i),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .wb_adr_i  (wb_adr_i),
    .wb_sel_i  (wb_sel_i),
    .wb_dat_i  (wb_dat_i),
    .wb_dat_o  (wb_dat_o),
    .wb_ack_o  (wb_ack_o),
    .boot_i    (boot_i),
    .temp_i    (temp_i),
    .ext_evt_i (ext_evt_i),
    .irq_o     (irq_o)
  );

  initial
  begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // Whole run needs well under two thousand cycles
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_irq(input logic exp);
    checks_done++;
    if (irq_o !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, irq_o, exp);
    end
  endtask : chk_irq

  // Request held until ack is seen at a rising edge
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] wd, input logic [3:0] sel);
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= sel;
    do @(posedge core_clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000, 4'hF);
    chk_word(rd, exp);
  endtask : rd_chk

  task automatic kick(input logic rs, input logic ld, input logic ce);
    @(posedge core_clk_i);
    boot_i.restart   <= rs;
    boot_i.load_done <= ld;
    boot_i.crc_err   <= ce;
    @(posedge core_clk_i);
    boot_i.restart   <= 1'b0;
    boot_i.load_done <= 1'b0;
    boot_i.crc_err   <= 1'b0;
  endtask : kick

  task automatic strobe_cfg(input logic [2:0] id, input logic ok,
                            input logic ee);
    @(posedge core_clk_i);
    boot_i.cfg_strobe  <= 1'b1;
    boot_i.cfg_id      <= id;
    boot_i.cfg_ok      <= ok;
    boot_i.from_eeprom <= ee;
    @(posedge core_clk_i);
    boot_i.cfg_strobe  <= 1'b0;
  endtask : strobe_cfg

  task automatic drop_levels();
    @(posedge core_clk_i);
    boot_i.seq_done  <= 1'b0;
    boot_i.dpll_lock <= 1'b0;
    kick(1'b1, 1'b0, 1'b0);
  endtask : drop_levels

  initial
  begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    boot_i = '0;
    temp_i = '0;
    ext_evt_i = '0;
    // Every user id once, both sources, both reset-done causes
    rows = '{'{3'h1, 1'b0, 1'b0, 32'h0000_00D1},
             '{3'h2, 1'b1, 1'b1, 32'h0000_00E2},
             '{3'h3, 1'b0, 1'b1, 32'h0000_00D3},
             '{3'h4, 1'b1, 1'b0, 32'h0000_00E4}};
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    chk_irq(1'b0);
    rd_chk(8'h00, 32'h0000_0000);
    rd_chk(8'h04, 32'h0000_0000);
    rd_chk(8'h48, 32'h0000_0000);
    foreach (rows[i])
    begin
      drop_levels();
      strobe_cfg(3'h0, 1'b1, 1'b0);
      strobe_cfg(rows[i].id, 1'b1, rows[i].ee);
      kick(1'b0, 1'b1, 1'b0);
      boot_i.seq_done  <= ~rows[i].lock;
      boot_i.dpll_lock <= rows[i].lock;
      rd_chk(8'h04, rows[i].exp);
    end
    rd_chk(8'h48, 32'h0000_0003);
    // Invalid sample cycles must not disturb the held code
    @(posedge core_clk_i);
    temp_i <= '{1'b1, 15'h7FFF};
    @(posedge core_clk_i);
    temp_i <= '{1'b0, 15'h1234};
    wb(1'b1, 8'h00, 32'hFFFF_FFFF, 4'hF);
    rd_chk(8'h00, 32'h0000_7FFF);
    @(posedge core_clk_i);
    temp_i <= '{1'b1, 15'h0000};
    @(posedge core_clk_i);
    temp_i.valid <= 1'b0;
    rd_chk(8'h00, 32'h0000_0000);
    // User load before common, then an out-of-range id
    drop_levels();
    strobe_cfg(3'h3, 1'b1, 1'b1);
    rd_chk(8'h04, 32'h0000_0000);
    strobe_cfg(3'h0, 1'b1, 1'b0);
    strobe_cfg(3'h5, 1'b1, 1'b1);
    kick(1'b0, 1'b0, 1'b1);
    wb(1'b1, 8'h04, 32'hFFFF_FFFF, 4'hF);
    rd_chk(8'h04, 32'h0000_0008);
    rd_chk(8'h48, 32'h0000_0007);
    chk_irq(1'b0);
    wb(1'b1, 8'h40, 32'h0000_0004, 4'hF);
    rd_chk(8'h40, 32'h0000_0004);
    chk_irq(1'b1);
    wb(1'b1, 8'h40, 32'h0000_0000, 4'hF);
    rd_chk(8'h40, 32'h0000_0000);
    chk_irq(1'b0);
    // Only the low byte lane may land
    wb(1'b1, 8'h40, 32'hFFFF_FF04, 4'h1);
    rd_chk(8'h40, 32'h0000_0004);
    chk_irq(1'b1);
    wb(1'b1, 8'h48, 32'h0000_0004, 4'hF);
    rd_chk(8'h48, 32'h0000_0003);
    chk_irq(1'b0);
    @(posedge core_clk_i);
    ext_evt_i <= 64'h0000_0100_0000_0000;
    @(posedge core_clk_i);
    ext_evt_i <= '0;
    rd_chk(8'h4C, 32'h0000_0100);
    chk_irq(1'b0);
    wb(1'b1, 8'h44, 32'h0000_0100, 4'hF);
    rd_chk(8'h44, 32'h0000_0100);
    chk_irq(1'b1);
    // Mid-run reset with the interrupt raised and read data held
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk_irq(1'b0);
    chk_word(wb_dat_o, 32'h0000_0000);
    rst_i <= 1'b0;
    rd_chk(8'h44, 32'h0000_0000);
    rd_chk(8'h4C, 32'h0000_0000);
    rd_chk(8'h04, 32'h0000_0000);
    wb(1'b1, 8'h80, 32'hFFFF_FFFF, 4'hF);
    rd_chk(8'h80, 32'h0000_0000);
    end_of_test();
  end

endmodule : testbench
